// File: dv/wwd_watchdog_bench.sv
// Self-checking bench for the windowed watchdog top, driving every port.
// Assumes hdl/ on the include path and clk_sys at 125 MHz.
`timescale 1ns/100ps
`include "wwd_defines.svh"
module wwd_watchdog_bench import wwd_pkg::*;;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [`WWD_ADDR_W-1:0] bus_addr = '0;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] opt_byte = 8'hFE;
    logic [7:0] opt_byte_two = 8'h0C;
    logic wait_mode = 1'b0;
    logic stop_mode = 1'b0;
    logic losc_tick = 1'b0;
    logic losc_run = 1'b0;
    logic [1:0] losc_div = 2'h0;
    logic [7:0] bus_rdata;
    logic wdt_irq;
    logic wdt_reset_req;
    logic losc_on;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    int irq_seen = 0;

    wwd_watchdog dut_u (.clk_sys(clk_sys), .reset(reset), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .opt_byte(opt_byte), .opt_byte_two(opt_byte_two), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .losc_tick(losc_tick), .wdt_irq(wdt_irq),
        .wdt_reset_req(wdt_reset_req), .losc_on(losc_on));

    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    // Low-speed oscillator stand-in: one tick every 4 system clocks
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        losc_div <= losc_div + 2'h1;
        losc_tick <= losc_run && losc_div == 2'h3;
        if (wdt_irq === 1'b1) irq_seen <= irq_seen + 1;
        if (cycles == 90000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk_n(input string what, input int lo, input int hi, input int got);
        total_checks++;
        if (got < lo || got > hi) begin
            failures++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic chk_b(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Options only change under reset; the design samples opt_byte at boot and reads opt_byte_two live
    task automatic rst(input logic [7:0] ob, input logic [7:0] ob2);
        @(posedge clk_sys);
        opt_byte <= ob;
        opt_byte_two <= ob2;
        reset <= 1'b1;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        // Let the boot edge settle before a caller looks at the outputs
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask

    // Issued only while the counter runs
    task automatic refresh();
        wr(`WWD_ADDR_REFRESH, 8'h00);
        wr(`WWD_ADDR_REFRESH, 8'hFF);
    endtask

    // Checks first, so a pulse launched by the caller's last edge is not missed
    task automatic wait_ev(input bit want_rst, input int lim, output int n);
        n = 0;
        #1;
        while (n < lim && (want_rst ? wdt_reset_req : wdt_irq) !== 1'b1) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask

    task automatic t_regs();
        logic [7:0] d;
        logic [7:0] hi [4] = '{8'h03, 8'h0F, 8'h1F, 8'h3F};
        int n;
        for (int p = 0; p < 4; p++) begin
            rst(8'hFE, 8'h0C | 8'(p));
            rd(`WWD_ADDR_CTRL, d);
            chk_b("period start", hi[p], d);
        end
        rd(`WWD_ADDR_OPT, d);
        chk_b("option byte", 8'hFE, d);
        wr(`WWD_ADDR_OPT, 8'h00);
        rd(`WWD_ADDR_OPT, d);
        chk_b("option byte kept", 8'hFE, d);
        rd(16'h0100, d);
        chk_b("unmapped read", 8'h00, d);
        wr(`WWD_ADDR_CTRL, 8'h80);
        rd(`WWD_ADDR_CTRL, d);
        chk_b("prescale select", 8'hBF, d);
        rst(8'hFE, 8'h0C);
        wait_ev(0, 16500, n);
        chk_n("ratio 16 period", 16376, 16392, n);
        $display("test regs done");
    endtask

    task automatic t_action();
        logic [7:0] d;
        int n;
        int k;
        rst(8'hFE, 8'h00);
        wr(`WWD_ADDR_CM0, 8'h80);
        wr(`WWD_ADDR_PM1, 8'h04);
        wr(`WWD_ADDR_PM1, 8'h00);
        rd(`WWD_ADDR_PM1, d);
        chk_b("action bit", 8'h04, d & 8'h04);
        k = irq_seen;
        refresh();
        wait_ev(1, 6, n);
        chk_n("early refresh reset", 0, 3, n);
        @(posedge clk_sys);
        wait_ev(1, 2200, n);
        chk_n("underflow reset", 1, 2100, n);
        chk_n("irq count", k, k, irq_seen);
        $display("test action done");
    endtask

    task automatic t_wait();
        int n;
        rst(8'hFE, 8'h0C);
        wr(`WWD_ADDR_CM0, 8'h80);
        wait_ev(0, 2200, n);
        repeat (500) @(posedge clk_sys);
        wait_mode <= 1'b1;
        repeat (100) @(posedge clk_sys);
        wait_mode <= 1'b0;
        stop_mode <= 1'b1;
        repeat (50) @(posedge clk_sys);
        stop_mode <= 1'b0;
        wait_ev(0, 2200, n);
        chk_n("paused period", 2194, 2202, n + 650);
        $display("test wait done");
    endtask

    // Codes 0 to 2 probe just outside and just inside the window edge; code 3 probes only inside
    task automatic t_window();
        int n;
        int dly;
        for (int w = 0; w < 4; w++) begin
            dly = 2 * (1024 - 256 * (w + 1));
            rst(8'hFE, 8'(w << 2));
            wr(`WWD_ADDR_CM0, 8'h80);
            wait_ev(0, 2200, n);
            if (w < 3) begin
                repeat (dly - 40) @(posedge clk_sys);
                refresh();
                wait_ev(0, 6, n);
                chk_n("refresh before window", 0, 3, n);
                @(posedge clk_sys);
                wait_ev(0, 2200, n);
            end
            repeat (dly + 40) @(posedge clk_sys);
            refresh();
            wait_ev(0, 2200, n);
            // Prescaler phase survives the refresh, so the tick beside it is lost
            chk_n("refresh in window", 2048, 2048, n);
        end
        $display("test window done");
    endtask

    task automatic t_start();
        int n;
        rst(8'hFF, 8'h00);
        wr(`WWD_ADDR_CM0, 8'h80);
        wait_ev(0, 2200, n);
        chk_n("stopped after reset", 2200, 2200, n);
        wr(`WWD_ADDR_START, 8'h5A);
        wait_ev(0, 2200, n);
        chk_n("count after start", 2040, 2056, n);
        $display("test start done");
    endtask

    task automatic t_prot();
        logic [7:0] d;
        int n;
        int k;
        rst(8'hFE, 8'h0C);
        chk_b("oscillator off", 8'h00, {7'h00, losc_on});
        wr(`WWD_ADDR_PROT, 8'h00);
        wr(`WWD_ADDR_PROT, 8'h80);
        rd(`WWD_ADDR_PROT, d);
        chk_b("protect set", 8'h80, d);
        chk_b("oscillator on", 8'h01, {7'h00, losc_on});
        rd(`WWD_ADDR_PM1, d);
        chk_b("forced action", 8'h04, d & 8'h04);
        rst(8'h7E, 8'h0C);
        chk_b("boot oscillator", 8'h01, {7'h00, losc_on});
        rd(`WWD_ADDR_PROT, d);
        chk_b("protect after reset", 8'h80, d);
        wr(`WWD_ADDR_PROT, 8'h00);
        rd(`WWD_ADDR_PROT, d);
        chk_b("protect kept", 8'h80, d);
        k = irq_seen;
        @(posedge clk_sys);
        wait_mode <= 1'b1;
        stop_mode <= 1'b1;
        losc_run <= 1'b1;
        wait_ev(1, 4300, n);
        @(posedge clk_sys);
        wait_ev(1, 4300, n);
        chk_n("oscillator period", 4092, 4100, n);
        chk_n("irq count", k, k, irq_seen);
        @(posedge clk_sys);
        wait_mode <= 1'b0;
        stop_mode <= 1'b0;
        losc_run <= 1'b0;
        $display("test prot done");
    endtask

    initial begin
        rst(8'hFE, 8'h0C);
        t_regs();
        t_action();
        t_wait();
        t_window();
        t_start();
        t_prot();
        end_of_test();
    end
endmodule // wwd_watchdog_bench

// File: hdl/wwd_defines.svh
// Constants of the windowed watchdog: register offsets, field positions,
// start values and prescale ratios. Assumes a byte-wide register port.
// Function
// (RULE_01) Refresh accepted only inside acknowledgement window
// (RULE_02) Window code selects 25/50/75/100 percent
// (RULE_03) Out-of-window refresh fires interrupt or reset
// (RULE_04) Software refreshes only while counting
// (RULE_05) Unprotected mode counts the CPU clock
// (RULE_06) Unprotected period is ratio 16/128/2 times count
// (RULE_07) Period option picks start value 03FFh..3FFFh
// (RULE_08) Reload on reset, underflow, 00h-FFh refresh
// (RULE_09) Prescaler cleared only by reset
// (RULE_10) Start option 1: wait for start write
// (RULE_11) Start option 0: count right after reset
// (RULE_12) Unprotected count pauses in wait and stop
// (RULE_13) Unprotected underflow: interrupt or reset by action bit
// (RULE_14) Start option bit is read-only
// (RULE_15) Protected mode counts low-speed oscillator ticks
// (RULE_16) Protected period is start count, no prescaler
// (RULE_17) Protected counting never halts
// (RULE_18) Protected underflow always resets
// (RULE_19) Protection bit enables oscillator, forces reset action
// (RULE_20) Protection-after-reset option 0 sets protection
// (RULE_21) Protection set by 0 then 1, never cleared
// (RULE_22) Action bit sticky: 1 sets, 0 ignored
// (RULE_23) Decrement per tick, underflow past zero
`ifndef WWD_DEFINES_SVH
`define WWD_DEFINES_SVH

`define WWD_ADDR_W 16
`define WWD_CNT_W 14
`define WWD_DIV_W 7

`define WWD_ADDR_PM1 16'h0005
`define WWD_ADDR_CM0 16'h0006
`define WWD_ADDR_REFRESH 16'h000D
`define WWD_ADDR_START 16'h000E
`define WWD_ADDR_CTRL 16'h000F
`define WWD_ADDR_PROT 16'h001C
`define WWD_ADDR_OPT2 16'hFFDB
`define WWD_ADDR_OPT 16'hFFFF

`define WWD_BIT_PRE_SEL 7
`define WWD_BIT_LS_SEL 7
`define WWD_BIT_ACTION 2
`define WWD_BIT_PROT 7
`define WWD_BIT_START_OPT 0
`define WWD_BIT_PROT_INI 7
`define WWD_UF_LSB 0
`define WWD_WIN_LSB 2

`define WWD_START_00 14'h03FF
`define WWD_START_01 14'h0FFF
`define WWD_START_10 14'h1FFF
`define WWD_START_11 14'h3FFF

`define WWD_REFRESH_FIRST 8'h00
`define WWD_REFRESH_SECOND 8'hFF

// Prescaler terminal counts are the ratio minus one, so 128 fits in seven bits
`define WWD_DIV_16 7'h0F
`define WWD_DIV_128 7'h7F
`define WWD_DIV_2 7'h01
`define WWD_WIN_FULL 2'h3

`endif

// File: hdl/wwd_pkg.sv
// Types shared by the watchdog modules.
// Assumes wwd_defines.svh is on the include path.
package wwd_pkg;
`include "wwd_defines.svh"

    typedef enum logic [1:0] {WWD_BOOT, WWD_STOPPED, WWD_RUN} wwd_mode_t;

    typedef struct packed {
        wwd_mode_t mode;
        logic [`WWD_CNT_W-1:0] cnt;
        logic refr_armed;
        logic prot_armed;
        logic prot;
        logic action;
        logic pre_sel;
        logic ls_sel;
        logic losc_on;
        logic irq;
        logic rst_req;
        logic [7:0] rd_data;
    } wwd_state_t;

    typedef struct packed {
        logic [`WWD_DIV_W-1:0] cnt;
        logic tick;
    } wwd_pre_state_t;
endpackage

// File: hdl/wwd_prescaler.sv
// Count-source prescaler: one tick every div_ratio+1 enabled cycles.
// Assumes the terminal count may change at any time; a count past it wraps at once.
`timescale 1ns/100ps
`include "wwd_defines.svh"
module wwd_prescaler import wwd_pkg::*; #(
    parameter int W = `WWD_DIV_W
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic enable,
    input wire logic [W-1:0] div_ratio,
    output logic tick
);
    wwd_pre_state_t st_reg;
    wwd_pre_state_t st_next;

    // Only reset clears the count, so a refresh leaves the phase alone
    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (enable) begin
            if (st_reg.cnt >= div_ratio) begin // see RULE_06
                st_next.cnt = '0;
                st_next.tick = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_reg <= '0; // see RULE_09
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick = st_reg.tick;

    a_tick_gap: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_06
        tick && div_ratio != '0 |=> !tick)
        else $error("prescaler ticked twice in a row");
endmodule // wwd_prescaler

// File: hdl/wwd_watchdog.sv
// Windowed watchdog top: registers, count control and underflow actions.
// Assumes option bytes are static flash levels and losc_tick is a
// one-cycle pulse per low-speed oscillator period, synchronous to clk_sys.
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`include "wwd_defines.svh"
module wwd_watchdog import wwd_pkg::*; #(
    parameter int CNT_W = `WWD_CNT_W,
    parameter int DIV_W = `WWD_DIV_W
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [`WWD_ADDR_W-1:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    input wire logic [7:0] opt_byte,
    input wire logic [7:0] opt_byte_two,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic losc_tick,
    output logic wdt_irq,
    output logic wdt_reset_req,
    output logic losc_on
);
    wwd_state_t st_reg;
    wwd_state_t st_next;

    logic [CNT_W-1:0] start_val;
    logic [1:0] uf_sel;
    logic [1:0] win_sel;
    logic in_window;
    logic halted;
    logic count_en;
    logic pre_tick;
    logic cnt_tick;
    logic [DIV_W-1:0] div_ratio;
    logic wr_refresh;
    logic refresh_done;
    logic refresh_ok;
    logic refresh_bad;
    logic underflow;
    logic fire;

    assign uf_sel = opt_byte_two[`WWD_UF_LSB +: 2];
    assign win_sel = opt_byte_two[`WWD_WIN_LSB +: 2];

    always_comb begin
        unique case (uf_sel) // see RULE_07
            2'b00: start_val = `WWD_START_00;
            2'b01: start_val = `WWD_START_01;
            2'b10: start_val = `WWD_START_10;
            2'b11: start_val = `WWD_START_11;
        endcase
    end

    // Low-speed clock select uses the shortest ratio so the period stays usable
    always_comb begin
        if (st_reg.ls_sel) begin
            div_ratio = `WWD_DIV_2; // see RULE_06
        end else if (st_reg.pre_sel) begin
            div_ratio = `WWD_DIV_128;
        end else begin
            div_ratio = `WWD_DIV_16;
        end
    end

    assign halted = !st_reg.prot && (wait_mode || stop_mode); // see RULE_12
    assign count_en = (st_reg.mode == WWD_RUN) && !halted; // see RULE_17

    wwd_prescaler #(
        .W(DIV_W)
    ) u_prescaler (
        .clk_sys(clk_sys),
        .reset(reset),
        .enable(count_en && !st_reg.prot), // see RULE_05
        .div_ratio(div_ratio),
        .tick(pre_tick)
    );

    wwd_window #(
        .W(CNT_W)
    ) u_window (
        .cnt(st_reg.cnt),
        .start(start_val),
        .win_sel(win_sel),
        .in_window(in_window)
    );

    // Protected mode bypasses the prescaler: one count per oscillator tick
    assign cnt_tick = st_reg.prot ? (losc_tick && st_reg.mode == WWD_RUN)
                                  : pre_tick; // see RULE_15 RULE_16

    assign wr_refresh = bus_wr && (bus_addr == `WWD_ADDR_REFRESH);
    // A refresh while stopped is ignored; software must not issue one
    assign refresh_done = wr_refresh && st_reg.refr_armed
        && (bus_wdata == `WWD_REFRESH_SECOND)
        && (st_reg.mode == WWD_RUN); // see RULE_04
    assign refresh_ok = refresh_done && in_window; // see RULE_01
    assign refresh_bad = refresh_done && !in_window; // see RULE_03
    assign underflow = cnt_tick && (st_reg.cnt == '0); // see RULE_23
    assign fire = refresh_bad || (underflow && !refresh_ok);

    always_comb begin
        st_next = st_reg;
        st_next.irq = 1'b0;
        st_next.rst_req = 1'b0;
        st_next.rd_data = '0;
        if (st_reg.mode == WWD_BOOT) begin
            // Option levels are caught on the first edge after release
            st_next.prot = !opt_byte[`WWD_BIT_PROT_INI]; // see RULE_20
            st_next.action = !opt_byte[`WWD_BIT_PROT_INI];
            st_next.losc_on = !opt_byte[`WWD_BIT_PROT_INI];
            st_next.cnt = start_val; // see RULE_08
            if (opt_byte[`WWD_BIT_START_OPT]) begin
                st_next.mode = WWD_STOPPED; // see RULE_10
            end else begin
                st_next.mode = WWD_RUN; // see RULE_11
            end
        end else begin
            if (bus_wr) begin
                unique case (bus_addr)
                    `WWD_ADDR_START: begin
                        if (st_reg.mode == WWD_STOPPED) begin
                            st_next.mode = WWD_RUN; // see RULE_10
                        end
                    end
                    `WWD_ADDR_CTRL: begin
                        st_next.pre_sel = bus_wdata[`WWD_BIT_PRE_SEL];
                    end
                    `WWD_ADDR_CM0: begin
                        st_next.ls_sel = bus_wdata[`WWD_BIT_LS_SEL];
                    end
                    `WWD_ADDR_PM1: begin
                        if (bus_wdata[`WWD_BIT_ACTION]) begin
                            st_next.action = 1'b1; // see RULE_22
                        end
                    end
                    `WWD_ADDR_PROT: begin
                        if (!bus_wdata[`WWD_BIT_PROT]) begin
                            st_next.prot_armed = 1'b1;
                        end else begin
                            st_next.prot_armed = 1'b0;
                            if (st_reg.prot_armed) begin
                                st_next.prot = 1'b1; // see RULE_21
                                st_next.action = 1'b1; // see RULE_19
                                st_next.losc_on = 1'b1;
                            end
                        end
                    end
                    `WWD_ADDR_REFRESH: begin
                        st_next.refr_armed = (bus_wdata == `WWD_REFRESH_FIRST);
                    end
                    default: begin
                    end
                endcase
            end
            // Refresh wins over a same-cycle tick; the prescaler keeps its phase
            if (refresh_ok) begin
                st_next.cnt = start_val; // see RULE_08
            end else if (cnt_tick) begin
                if (underflow) begin
                    st_next.cnt = start_val; // see RULE_08
                end else begin
                    st_next.cnt = st_reg.cnt - 1'b1; // see RULE_23
                end
            end
            // Illegal refresh and underflow in one cycle give one event
            if (fire) begin
                if (st_reg.action || st_reg.prot) begin
                    st_next.rst_req = 1'b1; // see RULE_13 RULE_18
                end else begin
                    st_next.irq = 1'b1; // see RULE_13
                end
            end
        end
        if (bus_rd) begin
            unique case (bus_addr)
                `WWD_ADDR_CTRL: st_next.rd_data = {st_reg.pre_sel, 1'b0,
                                                   st_reg.cnt[CNT_W-1 -: 6]};
                `WWD_ADDR_CM0: st_next.rd_data = {st_reg.ls_sel, 7'h00};
                `WWD_ADDR_PM1: st_next.rd_data = {5'h00, st_reg.action, 2'h0};
                `WWD_ADDR_PROT: st_next.rd_data = {st_reg.prot, 7'h00};
                `WWD_ADDR_OPT: st_next.rd_data = opt_byte; // see RULE_14
                `WWD_ADDR_OPT2: st_next.rd_data = opt_byte_two;
                default: st_next.rd_data = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus_rdata = st_reg.rd_data;
    assign wdt_irq = st_reg.irq;
    assign wdt_reset_req = st_reg.rst_req;
    assign losc_on = st_reg.losc_on;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    a_refresh_reload: assert property ( // see RULE_08
        refresh_ok |=> st_reg.cnt == $past(start_val))
        else $error("accepted refresh did not reload the counter");

    a_illegal_refresh: assert property ( // see RULE_03
        refresh_bad |=> (wdt_irq || wdt_reset_req))
        else $error("out-of-window refresh raised no event");

    a_window_block: assert property ( // see RULE_01
        refresh_done && !in_window && !underflow |=> st_reg.cnt != $past(start_val)
            || $past(st_reg.cnt) == start_val)
        else $error("refresh outside the window reloaded the counter");

    a_uf_irq: assert property ( // see RULE_13
        underflow && !refresh_ok && !st_reg.action && !st_reg.prot
            |=> wdt_irq && !wdt_reset_req && st_reg.cnt == $past(start_val))
        else $error("underflow with action 0 gave no interrupt");

    a_prot_no_irq: assert property ( // see RULE_18
        st_reg.prot |=> !wdt_irq)
        else $error("protected mode raised an interrupt");

    a_prot_sticky: assert property ( // see RULE_21
        st_reg.prot |=> st_reg.prot && st_reg.action && losc_on)
        else $error("protection bit or its companions dropped");

    a_action_sticky: assert property ( // see RULE_22
        st_reg.action |=> st_reg.action)
        else $error("underflow action bit was cleared");

    a_halt_hold: assert property ( // see RULE_12
        st_reg.mode == WWD_RUN && !st_reg.prot && (wait_mode || stop_mode)
            && !refresh_done ##1 (wait_mode || stop_mode) && !refresh_done
            |=> $stable(st_reg.cnt))
        else $error("counter moved while halted");

    a_stopped_hold: assert property ( // see RULE_10
        st_reg.mode == WWD_STOPPED && !(bus_wr && bus_addr == `WWD_ADDR_START)
            |=> st_reg.mode == WWD_STOPPED && $stable(st_reg.cnt))
        else $error("stopped watchdog counted without a start write");

    a_rdata_idle: assert property (
        !bus_rd |=> bus_rdata == '0)
        else $error("read data outside the read answer cycle");

    a_boot_prot: assert property ( // see RULE_20
        st_reg.mode == WWD_BOOT && !opt_byte[`WWD_BIT_PROT_INI]
            |=> st_reg.prot && st_reg.action && losc_on)
        else $error("protection option ignored at boot");

    a_boot_unprot: assert property ( // see RULE_20
        st_reg.mode == WWD_BOOT && opt_byte[`WWD_BIT_PROT_INI]
            |=> !st_reg.prot && !losc_on)
        else $error("protection set at boot without its option");

    a_boot_run: assert property ( // see RULE_11
        st_reg.mode == WWD_BOOT && !opt_byte[`WWD_BIT_START_OPT]
            |=> st_reg.mode == WWD_RUN && st_reg.cnt == $past(start_val))
        else $error("watchdog did not start counting after reset");

    a_boot_stop: assert property ( // see RULE_10
        st_reg.mode == WWD_BOOT && opt_byte[`WWD_BIT_START_OPT]
            |=> st_reg.mode == WWD_STOPPED && st_reg.cnt == $past(start_val))
        else $error("watchdog did not stay stopped after reset");

    a_start_run: assert property ( // see RULE_10
        st_reg.mode == WWD_STOPPED && bus_wr && bus_addr == `WWD_ADDR_START
            |=> st_reg.mode == WWD_RUN)
        else $error("start write did not start the counter");

    a_prot_set: assert property ( // see RULE_21 RULE_19
        st_reg.mode != WWD_BOOT && bus_wr && bus_addr == `WWD_ADDR_PROT
            && bus_wdata[`WWD_BIT_PROT] && st_reg.prot_armed
            |=> st_reg.prot && st_reg.action && losc_on)
        else $error("armed protection write did not take effect");

    a_prot_unarmed: assert property ( // see RULE_21
        st_reg.mode != WWD_BOOT && !st_reg.prot && !st_reg.prot_armed |=> !st_reg.prot)
        else $error("protection set without a preceding zero write");

    a_prot_companion: assert property ( // see RULE_19
        st_reg.prot |-> st_reg.action && losc_on)
        else $error("protection without oscillator or reset action");

    a_action_set: assert property ( // see RULE_22
        st_reg.mode != WWD_BOOT && bus_wr && bus_addr == `WWD_ADDR_PM1
            && bus_wdata[`WWD_BIT_ACTION] |=> st_reg.action)
        else $error("writing one did not set the action bit");

    a_prot_reset: assert property ( // see RULE_18
        underflow && st_reg.prot && !refresh_ok
            |=> wdt_reset_req && !wdt_irq)
        else $error("protected underflow gave no reset request");

    a_uf_reset: assert property ( // see RULE_13
        underflow && st_reg.action && !refresh_ok
            |=> wdt_reset_req && !wdt_irq)
        else $error("underflow with action 1 gave no reset request");

    a_uf_reload: assert property ( // see RULE_08
        underflow |=> st_reg.cnt == $past(start_val))
        else $error("underflow did not reload the counter");

    a_decrement: assert property ( // see RULE_23
        cnt_tick && !underflow && !refresh_ok
            |=> st_reg.cnt == $past(st_reg.cnt) - 1'b1)
        else $error("count tick did not decrement by one");

    a_refresh_quiet: assert property ( // see RULE_01
        refresh_ok |=> !wdt_irq && !wdt_reset_req)
        else $error("accepted refresh raised an event");

    a_prot_run: assert property ( // see RULE_17 RULE_15
        st_reg.prot && st_reg.mode == WWD_RUN && losc_tick |-> cnt_tick)
        else $error("protected counter skipped an oscillator tick");

    a_unprot_halt: assert property ( // see RULE_12
        halted ##1 halted |-> !cnt_tick)
        else $error("unprotected counter ticked while halted");

    a_opt_read: assert property ( // see RULE_14
        bus_rd && bus_addr == `WWD_ADDR_OPT |=> bus_rdata == $past(opt_byte))
        else $error("option byte read back wrong");

    a_refresh_arm: assert property ( // see RULE_08
        st_reg.mode != WWD_BOOT && wr_refresh && bus_wdata == `WWD_REFRESH_FIRST
            |=> st_reg.refr_armed)
        else $error("first refresh write did not arm");

    a_refresh_disarm: assert property ( // see RULE_08
        st_reg.mode != WWD_BOOT && wr_refresh && bus_wdata != `WWD_REFRESH_FIRST
            |=> !st_reg.refr_armed)
        else $error("other refresh value left the refresh armed");

    c_halted: cover property (halted ##1 halted);
    c_refresh_ok: cover property (refresh_ok);
    c_refresh_bad: cover property (refresh_bad);
    c_underflow: cover property (underflow ##1 wdt_reset_req);
    c_prot_set: cover property (!st_reg.prot ##1 st_reg.prot);
endmodule // wwd_watchdog

// File: hdl/wwd_window.sv
// Refresh acknowledgement window check, purely combinational.
// Assumes start+1 is a power of two, so quarters are exact.
`timescale 1ns/100ps
`include "wwd_defines.svh"
module wwd_window import wwd_pkg::*; #(
    parameter int W = `WWD_CNT_W
) (
    input wire logic [W-1:0] cnt,
    input wire logic [W-1:0] start,
    input wire logic [1:0] win_sel,
    output logic in_window
);
    logic [W+1:0] quarter;
    logic [W+1:0] limit;

    // The window is the last 25..100 percent of the period before underflow
    always_comb begin
        quarter = ({2'b00, start} + 1'b1) >> 2;
        limit = (quarter * ({{W{1'b0}}, win_sel} + 1'b1)) - 1'b1; // see RULE_02
        in_window = (win_sel == `WWD_WIN_FULL) || ({2'b00, cnt} <= limit); // see RULE_01
    end
endmodule // wwd_window
